// File: scc_coproc.sv
// System control coprocessor register map facing the core pipeline
`timescale 1ns/1ps
// Function
// - Reserved numbers read zero, ignore writes
// - Provides exception, mode, interrupt and diagnostic control
// - Tracks kernel, user or debug mode
// - Number 7 holds hardware-register access enables
// - Number 8 captures latest faulting address
// - Number 12 holds processor status word
// - Number 12 also holds interrupt control
// - Number 12 also holds shadow set control
// - Number 12 also maps vectors to shadow sets
// - Number 13 records latest exception cause
// - Number 14 captures exception return pc
// - Number 15 gives read-only identification
// - Number 15 also holds exception vector base
// - Number 16 reports optional feature presence
// - Number 23 holds debug control and status
// - Number 24 captures debug return pc
// - Number 30 captures error return pc
// - Number 31 is a debug scratchpad
module scc_coproc (
   input  wire logic        clk_sys,          // System clock, 200 MHz
   input  wire logic        reset,            // Synchronous reset, active high
   input  wire logic        acc_rd,           // Register read request
   input  wire logic        acc_wr,           // Register write request
   input  wire logic [4:0]  acc_num,          // Register number
   input  wire logic [2:0]  acc_sel,          // Register select
   input  wire logic [31:0] acc_wdata,        // Write data
   output logic      [31:0] acc_rdata,        // Read data, registered
   output logic             acc_hit,          // Last read hit a register
   input  wire logic        addr_exc,         // Address-related exception
   input  wire logic [31:0] addr_exc_va,      // Faulting address
   input  wire logic        exc_take,         // General exception taken
   input  wire logic [4:0]  exc_code,         // Exception code
   input  wire logic [31:0] exc_pc,           // Pc of excepting instruction
   input  wire logic [2:0]  int_vector,       // Vector number of interrupt
   input  wire logic [5:0]  int_pending,      // Hardware interrupt lines
   input  wire logic        err_take,         // Error exception taken
   input  wire logic [31:0] err_pc,           // Pc at error
   input  wire logic        dbg_take,         // Debug exception taken
   input  wire logic [31:0] dbg_pc,           // Pc at debug exception
   input  wire logic [5:0]  dbg_cause,        // Debug exception status bits
   input  wire logic        exc_return,       // Return from exception
   input  wire logic        dbg_return,       // Return from debug
   output logic      [2:0]  cpu_mode,         // One-hot: kernel, user, debug
   output logic             int_enable,       // Interrupts globally enabled
   output logic             timer_irq,        // Timer interrupt request
   output logic      [31:0] exc_vector_base,  // General exception vector
   output logic      [3:0]  hw_access_enable, // Access enables for hw reads
   output logic      [3:0]  shadow_set,       // Current shadow set
   output logic      [4:0]  vector_spacing    // Vector spacing field
);
   import scc_pkg::*;

   typedef enum logic [2:0] {
      MODE_KERNEL = 3'b001,
      MODE_USER   = 3'b010,
      MODE_DEBUG  = 3'b100
   } scc_mode_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic [31:0] cmp;
      logic        ti;
      logic [31:0] hwena;
      logic [31:0] status;
      logic [31:0] interrupt_control_reg;
      logic [31:0] shadow_set_control;
      logic [31:0] shadow_set_map;
      logic [4:0]  code;
      logic [1:0]  swint;
      logic [31:0] exception_vector_base;
      logic [31:0] debug;
      logic [31:0] scratch;
      scc_mode_t   mode;
      logic [31:0] rdata;
      logic        hit;
   } scc_state_t;

   scc_state_t  st_reg;
   scc_state_t  st_next;

   logic [31:0] fault_adr;
   logic [31:0] exc_ret_pc;
   logic [31:0] dbg_ret_pc;
   logic [31:0] err_ret_pc;
   logic        wr_faultadr;
   logic        wr_excpc;
   logic        wr_dbgpc;
   logic        wr_errpc;
   logic        epc_cap;
   logic        cmp_match;
   logic [31:0] cause_rd;

   // Write strobes for the faulting address and the captured program counters
   assign wr_faultadr = 1'b0;  // Faulting address is read-only
   assign wr_excpc    = acc_wr && acc_num == NUM_EXCPC;
   assign wr_dbgpc    = acc_wr && acc_num == NUM_DBGPC;
   assign wr_errpc    = acc_wr && acc_num == NUM_ERRPC;
   // Nested exception keeps the outer return pc
   assign epc_cap     = exc_take && !st_reg.status[ST_EXL];
   assign cmp_match   = st_reg.cnt == st_reg.cmp;

   // Faulting address capture
   scc_capture_reg u_fault_adr (
      .clk_sys (clk_sys),
      .reset   (reset),
      .cap_en  (addr_exc),
      .cap_val (addr_exc_va),
      .wr_en   (wr_faultadr),
      .wr_val  (acc_wdata),
      .value   (fault_adr)
   );

   // Exception return pc
   scc_capture_reg u_exc_pc (
      .clk_sys (clk_sys),
      .reset   (reset),
      .cap_en  (epc_cap),
      .cap_val (exc_pc),
      .wr_en   (wr_excpc),
      .wr_val  (acc_wdata),
      .value   (exc_ret_pc)
   );

   // Debug return pc
   scc_capture_reg u_dbg_pc (
      .clk_sys (clk_sys),
      .reset   (reset),
      .cap_en  (dbg_take),
      .cap_val (dbg_pc),
      .wr_en   (wr_dbgpc),
      .wr_val  (acc_wdata),
      .value   (dbg_ret_pc)
   );

   // Error return pc
   scc_capture_reg u_err_pc (
      .clk_sys (clk_sys),
      .reset   (reset),
      .cap_en  (err_take),
      .cap_val (err_pc),
      .wr_en   (wr_errpc),
      .wr_val  (acc_wdata),
      .value   (err_ret_pc)
   );

   // Cause as seen by the core: timer, hardware and software pending, code
   always_comb begin
      cause_rd                         = '0;
      cause_rd[CA_TI]                  = st_reg.ti;
      cause_rd[CA_IP_LO+7 -: 6]        = int_pending;
      cause_rd[CA_IP_LO+1 -: 2]        = st_reg.swint;
      cause_rd[CA_CODE_LO+4 -: 5]      = st_reg.code;
   end

   // Next-state logic for all coprocessor state outside the capture registers
   always_comb begin
      st_next = st_reg;
      // Counter runs every cycle; a write reloads it
      if (acc_wr && acc_num == NUM_COUNT) begin
         st_next.cnt = acc_wdata;
      end else begin
         st_next.cnt = st_reg.cnt + 32'h0000_0001;
      end
      // Compare write clears the timer flag, but a match in the same cycle wins
      if (acc_wr && acc_num == NUM_COMPARE) begin
         st_next.cmp = acc_wdata;
         st_next.ti  = 1'b0;
      end
      if (cmp_match) begin
         st_next.ti = 1'b1;
      end
      // Core writes to the control words, masked to writable fields
      if (acc_wr) begin
         case (acc_num)
            NUM_HWENA: begin
               st_next.hwena = acc_wdata & HWENA_WMASK;
            end
            NUM_STATUS: begin
               case (acc_sel)
                  SEL_0: begin
                     st_next.status = (st_reg.status & ~STATUS_WMASK)
                                    | (acc_wdata & STATUS_WMASK);
                  end
                  SEL_1: begin
                     st_next.interrupt_control_reg = acc_wdata & INTERRUPT_CONTROL_REG_WMASK;
                  end
                  SEL_2: begin
                     st_next.shadow_set_control = (st_reg.shadow_set_control & ~SHADOW_SET_CONTROL_WMASK)
                                    | (acc_wdata & SHADOW_SET_CONTROL_WMASK);
                  end
                  SEL_3: begin
                     st_next.shadow_set_map = acc_wdata;
                  end
                  default: begin
                     st_next.status = st_reg.status;
                  end
               endcase
            end
            NUM_CAUSE: begin
               st_next.swint = acc_wdata[CA_IP_LO+1 -: 2];
            end
            NUM_PROCESSOR_ID_REVISION: begin
               if (acc_sel == SEL_1) begin
                  st_next.exception_vector_base = (st_reg.exception_vector_base & ~EXCEPTION_VECTOR_BASE_WMASK)
                                | (acc_wdata & EXCEPTION_VECTOR_BASE_WMASK);
               end
            end
            NUM_DEBUG: begin
               st_next.debug = (st_reg.debug & ~DEBUG_WMASK)
                             | (acc_wdata & DEBUG_WMASK);
            end
            NUM_SCRATCH: begin
               st_next.scratch = acc_wdata;
            end
            // Reserved and read-only numbers take no write
            default: begin
               st_next.hwena = st_reg.hwena;
            end
         endcase
      end
      // Events override writes: error, then exception, then returns
      if (err_take) begin
         st_next.status[ST_ERL] = 1'b1;
      end
      if (exc_take) begin
         st_next.status[ST_EXL] = 1'b1;
         st_next.code           = exc_code;
         if (exc_code == CODE_INT) begin
            // Interrupt switches register set via the map
            st_next.shadow_set_control[SS_PSS_LO+3 -: 4] = st_reg.shadow_set_control[SS_CSS_LO+3 -: 4];
            st_next.shadow_set_control[SS_CSS_LO+3 -: 4] =
               st_reg.shadow_set_map[{int_vector, 2'b00} +: 4];
         end
      end else if (exc_return && !err_take) begin
         if (st_reg.status[ST_ERL]) begin
            st_next.status[ST_ERL] = 1'b0;
         end else begin
            st_next.status[ST_EXL] = 1'b0;
            st_next.shadow_set_control[SS_CSS_LO+3 -: 4] = st_reg.shadow_set_control[SS_PSS_LO+3 -: 4];
         end
      end
      // Debug entry and exit
      if (dbg_take) begin
         st_next.debug[DB_DM]  = 1'b1;
         st_next.debug[5:0]    = dbg_cause;
      end else if (dbg_return) begin
         st_next.debug[DB_DM]  = 1'b0;
      end
      // Mode follows the state that will hold next cycle
      if (st_next.debug[DB_DM]) begin
         st_next.mode = MODE_DEBUG;
      end else if (st_next.status[ST_EXL] || st_next.status[ST_ERL]
                   || !st_next.status[ST_UM]) begin
         st_next.mode = MODE_KERNEL;
      end else begin
         st_next.mode = MODE_USER;
      end
      // Read mux; a miss reads as zero
      st_next.rdata = '0;
      st_next.hit   = 1'b0;
      if (acc_rd) begin
         st_next.hit = 1'b1;
         case (acc_num)
            NUM_HWENA:    st_next.rdata = st_reg.hwena;
            NUM_FAULTADR: st_next.rdata = fault_adr;
            NUM_COUNT:    st_next.rdata = st_reg.cnt;
            NUM_COMPARE:  st_next.rdata = st_reg.cmp;
            NUM_STATUS: begin
               case (acc_sel)
                  SEL_0:   st_next.rdata = st_reg.status;
                  SEL_1:   st_next.rdata = INTERRUPT_CONTROL_REG_FIXED | st_reg.interrupt_control_reg;
                  SEL_2:   st_next.rdata = st_reg.shadow_set_control;
                  SEL_3:   st_next.rdata = st_reg.shadow_set_map;
                  default: st_next.hit   = 1'b0;
               endcase
            end
            NUM_CAUSE:    st_next.rdata = cause_rd;
            NUM_EXCPC:    st_next.rdata = exc_ret_pc;
            NUM_PROCESSOR_ID_REVISION: begin
               case (acc_sel)
                  SEL_0:   st_next.rdata = PROCESSOR_ID_REVISION_VALUE;
                  SEL_1:   st_next.rdata = st_reg.exception_vector_base;
                  default: st_next.hit   = 1'b0;
               endcase
            end
            NUM_CONFIG: begin
               case (acc_sel)
                  SEL_0:   st_next.rdata = CONFIG0_VAL;
                  SEL_1:   st_next.rdata = CONFIG1_VAL;
                  SEL_2:   st_next.rdata = CONFIG2_VAL;
                  SEL_3:   st_next.rdata = CONFIG3_VAL;
                  default: st_next.hit   = 1'b0;
               endcase
            end
            NUM_DEBUG:    st_next.rdata = st_reg.debug;
            NUM_DBGPC:    st_next.rdata = dbg_ret_pc;
            NUM_ERRPC:    st_next.rdata = err_ret_pc;
            NUM_SCRATCH:  st_next.rdata = st_reg.scratch;
            default:      st_next.hit   = 1'b0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_reg         <= '0;
         st_reg.status  <= STATUS_RST;
         st_reg.exception_vector_base   <= EXCEPTION_VECTOR_BASE_RST;
         st_reg.debug   <= ZERO_RST;
         st_reg.mode    <= MODE_KERNEL;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs to the core; interrupts only outside exception and debug
   assign acc_rdata        = st_reg.rdata;
   assign acc_hit          = st_reg.hit;
   assign cpu_mode         = st_reg.mode;
   assign int_enable       = st_reg.status[ST_IE] && !st_reg.status[ST_EXL]
                             && !st_reg.status[ST_ERL] && !st_reg.debug[DB_DM];
   assign timer_irq        = st_reg.ti && st_reg.status[ST_IM_LO+7] && int_enable;
   assign exc_vector_base  = st_reg.status[ST_BEV] ? BOOT_VECTOR
                             : (st_reg.exception_vector_base + GEN_VEC_OFS);
   assign hw_access_enable = st_reg.hwena[3:0];
   assign shadow_set       = st_reg.shadow_set_control[SS_CSS_LO+3 -: 4];
   assign vector_spacing   = st_reg.interrupt_control_reg[9:5];

   // Checks
   chk_reserved_reads_zero: assert property (@(posedge clk_sys) disable iff (reset)
      acc_rd && (acc_num < NUM_HWENA || acc_num == 5'h0A
                 || (acc_num > NUM_CONFIG && acc_num < NUM_DEBUG)
                 || (acc_num > NUM_DBGPC && acc_num < NUM_ERRPC))
      |=> acc_rdata == 32'h0000_0000 && !acc_hit)
      else $error("reserved number read nonzero");
   chk_mode_debug_entry: assert property (@(posedge clk_sys) disable iff (reset)
      dbg_take |=> cpu_mode == MODE_DEBUG && !int_enable)
      else $error("debug entry did not enter debug mode");
   chk_fault_adr_read: assert property (@(posedge clk_sys) disable iff (reset)
      addr_exc |=> fault_adr == $past(addr_exc_va))
      else $error("faulting address not reported");
   // Exceptions taken in debug mode stay in debug mode, so only user is ruled out
   chk_exl_on_exception: assert property (@(posedge clk_sys) disable iff (reset)
      exc_take |=> st_reg.status[ST_EXL] && cpu_mode != MODE_USER)
      else $error("exception did not set level");
   chk_cause_code_kept: assert property (@(posedge clk_sys) disable iff (reset)
      exc_take |=> st_reg.code == $past(exc_code))
      else $error("cause code not recorded");
   chk_ret_pc_capture: assert property (@(posedge clk_sys) disable iff (reset)
      epc_cap |=> exc_ret_pc == $past(exc_pc))
      else $error("exception pc not captured");
   chk_processor_id_revision_constant: assert property (@(posedge clk_sys) disable iff (reset)
      acc_rd && acc_num == NUM_PROCESSOR_ID_REVISION && acc_sel == SEL_0 |=> acc_rdata == PROCESSOR_ID_REVISION_VALUE)
      else $error("identification value wrong");
   chk_dbg_pc_capture: assert property (@(posedge clk_sys) disable iff (reset)
      dbg_take |=> dbg_ret_pc == $past(dbg_pc)
                   ##1 (dbg_ret_pc == $past(dbg_pc, 2) || $past(dbg_take) || $past(wr_dbgpc)))
      else $error("debug pc not captured");
   chk_err_pc_capture: assert property (@(posedge clk_sys) disable iff (reset)
      err_take |=> err_ret_pc == $past(err_pc) && st_reg.status[ST_ERL])
      else $error("error pc not captured");
   chk_scratch_write: assert property (@(posedge clk_sys) disable iff (reset)
      acc_wr && acc_num == NUM_SCRATCH |=> st_reg.scratch == $past(acc_wdata))
      else $error("scratchpad write lost");
   chk_count_step: assert property (@(posedge clk_sys) disable iff (reset)
      !(acc_wr && acc_num == NUM_COUNT) |=> st_reg.cnt == $past(st_reg.cnt) + 32'h0000_0001)
      else $error("counter did not advance");
   chk_timer_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
      cmp_match |=> st_reg.ti)
      else $error("compare match lost");

   cov_exception_taken: cover property (@(posedge clk_sys) disable iff (reset)
      exc_take ##[1:20] exc_return);
   cov_debug_session: cover property (@(posedge clk_sys) disable iff (reset)
      dbg_take ##[1:20] dbg_return);
   cov_timer_irq: cover property (@(posedge clk_sys) disable iff (reset) timer_irq);
   cov_user_mode: cover property (@(posedge clk_sys) disable iff (reset)
      cpu_mode == MODE_USER);
endmodule : scc_coproc

// File: scc_pkg.sv
// Package: register numbers, field positions and reset values of the control coprocessor
package scc_pkg;
   // Register numbers
   localparam logic [4:0] NUM_HWENA    = 5'h07;
   localparam logic [4:0] NUM_FAULTADR = 5'h08;
   localparam logic [4:0] NUM_COUNT    = 5'h09;
   localparam logic [4:0] NUM_COMPARE  = 5'h0B;
   localparam logic [4:0] NUM_STATUS   = 5'h0C;
   localparam logic [4:0] NUM_CAUSE    = 5'h0D;
   localparam logic [4:0] NUM_EXCPC    = 5'h0E;
   localparam logic [4:0] NUM_PROCESSOR_ID_REVISION     = 5'h0F;
   localparam logic [4:0] NUM_CONFIG   = 5'h10;
   localparam logic [4:0] NUM_DEBUG    = 5'h17;
   localparam logic [4:0] NUM_DBGPC    = 5'h18;
   localparam logic [4:0] NUM_ERRPC    = 5'h1E;
   localparam logic [4:0] NUM_SCRATCH  = 5'h1F;
   // Select values within shared numbers
   localparam logic [2:0] SEL_0        = 3'h0;
   localparam logic [2:0] SEL_1        = 3'h1;
   localparam logic [2:0] SEL_2        = 3'h2;
   localparam logic [2:0] SEL_3        = 3'h3;
   // Status field positions
   localparam int         ST_IE        = 0;
   localparam int         ST_EXL       = 1;
   localparam int         ST_ERL       = 2;
   localparam int         ST_UM        = 4;
   localparam int         ST_IM_LO     = 8;
   localparam int         ST_BEV       = 22;
   // Cause field positions
   localparam int         CA_CODE_LO   = 2;
   localparam int         CA_IP_LO     = 8;
   localparam int         CA_TI        = 30;
   // Shadow set control field positions
   localparam int         SS_CSS_LO    = 0;
   localparam int         SS_PSS_LO    = 6;
   // Debug field positions
   localparam int         DB_DM        = 30;
   // Writable masks
   localparam logic [31:0] HWENA_WMASK  = 32'h0000_000F;
   localparam logic [31:0] STATUS_WMASK = 32'h0040_FF17;
   localparam logic [31:0] INTERRUPT_CONTROL_REG_WMASK = 32'h0000_03E0;
   localparam logic [31:0] SHADOW_SET_CONTROL_WMASK = 32'h0000_F3C0;
   localparam logic [31:0] CAUSE_WMASK  = 32'h0000_0300;
   localparam logic [31:0] EXCEPTION_VECTOR_BASE_WMASK  = 32'h3FFF_F000;
   localparam logic [31:0] DEBUG_WMASK  = 32'h0000_0300;
   // Reset values and fixed read bits
   localparam logic [31:0] STATUS_RST   = 32'h0040_0004;
   localparam logic [31:0] EXCEPTION_VECTOR_BASE_RST    = 32'h8000_0000;
   localparam logic [31:0] ZERO_RST     = 32'h0000_0000;
   localparam logic [31:0] INTERRUPT_CONTROL_REG_FIXED = 32'hE000_0000;
   // Read-only identity and configuration (identity value is arbitrary)
   localparam logic [31:0] PROCESSOR_ID_REVISION_VALUE   = 32'h00A5_5A01;
   localparam logic [31:0] CONFIG0_VAL  = 32'h8000_0483;
   localparam logic [31:0] CONFIG1_VAL  = 32'h8000_0004;
   localparam logic [31:0] CONFIG2_VAL  = 32'h8000_0000;
   localparam logic [31:0] CONFIG3_VAL  = 32'h0000_0020;
   // Boot vector address and general vector offset
   localparam logic [31:0] BOOT_VECTOR  = 32'hBFC0_0380;
   localparam logic [31:0] GEN_VEC_OFS  = 32'h0000_0180;
   // Exception codes
   localparam logic [4:0] CODE_INT     = 5'h00;
endpackage : scc_pkg

// File: scc_capture_reg.sv
// Capture register: loads on a hardware event, else on a core write
`timescale 1ns/1ps
module scc_capture_reg (
   input  wire logic        clk_sys,   // System clock
   input  wire logic        reset,     // Synchronous reset, active high
   input  wire logic        cap_en,    // Hardware capture strobe
   input  wire logic [31:0] cap_val,   // Value captured by hardware
   input  wire logic        wr_en,     // Core write strobe
   input  wire logic [31:0] wr_val,    // Value written by core
   output logic      [31:0] value      // Held value
);
   import scc_pkg::*;

   typedef struct packed {
      logic [31:0] val;
   } scc_cap_state_t;

   scc_cap_state_t st_reg;
   scc_cap_state_t st_next;

   // Hardware event wins over a write in the same cycle
   always_comb begin
      st_next = st_reg;
      if (cap_en) begin
         st_next.val = cap_val;
      end else if (wr_en) begin
         st_next.val = wr_val;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign value = st_reg.val;

   chk_capture_wins: assert property (@(posedge clk_sys) disable iff (reset)
      cap_en |=> value == $past(cap_val))
      else $error("capture value not held");
endmodule : scc_capture_reg

// File: scc_core_model.sv
// Core pipeline model issuing coprocessor register moves
`timescale 1ns/1ps
module scc_core_model (
   input  wire logic        clk_sys,   // System clock
   output logic             acc_rd,    // Read request
   output logic             acc_wr,    // Write request
   output logic      [4:0]  acc_num,   // Register number
   output logic      [2:0]  acc_sel,   // Register select
   output logic      [31:0] acc_wdata, // Write data
   input  wire logic [31:0] acc_rdata, // Read data
   input  wire logic        acc_hit    // Read hit flag
);
   // Quiet bus from time zero
   initial begin
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      acc_num = 5'h00;
      acc_sel = 3'h0;
      acc_wdata = 32'h0;
   end
   // One move a call; answer taken in the cycle after the request edge
   task automatic move(input logic rd, input logic wr, input logic [4:0] num,
                       input logic [2:0] sel, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic hit);
      @(posedge clk_sys);
      acc_rd <= rd;
      acc_wr <= wr;
      acc_num <= num;
      acc_sel <= sel;
      acc_wdata <= wd;
      @(posedge clk_sys);
      acc_rd <= 1'b0;
      acc_wr <= 1'b0;
      acc_wdata <= ~wd;  // Stale data never left to look valid
      #1;
      rdat = acc_rdata;
      hit = acc_hit;
   endtask : move
endmodule : scc_core_model

// File: tb_top.sv
// Self-checking bench for the control coprocessor register map
`timescale 1ns/1ps
module tb_top;
   import scc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [5:0]  evs = 6'h00;
   logic [31:0] ev_val = 32'h0;
   logic [4:0]  ecode = 5'h04;
   logic        acc_rd, acc_wr, acc_hit, hit, timer_irq, int_enable;
   logic [4:0]  acc_num, vector_spacing;
   logic [2:0]  acc_sel, cpu_mode;
   logic [31:0] acc_wdata, acc_rdata, rdat, exc_vector_base;
   logic [3:0]  hw_access_enable, shadow_set;
   int          failures = 0;
   int          checks = 0;
   // Half-period toggle for 200 MHz
   always #2.5 clk_sys = ~clk_sys;
   scc_core_model core (.clk_sys(clk_sys), .acc_rd(acc_rd), .acc_wr(acc_wr),
      .acc_num(acc_num), .acc_sel(acc_sel), .acc_wdata(acc_wdata),
      .acc_rdata(acc_rdata), .acc_hit(acc_hit));
   // Debug status held fixed; pcs share one event value
   scc_coproc DUT (.clk_sys(clk_sys), .reset(reset), .acc_rd(acc_rd), .acc_wr(acc_wr),
      .acc_num(acc_num), .acc_sel(acc_sel), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
      .acc_hit(acc_hit), .addr_exc(evs[0]), .addr_exc_va(ev_val), .exc_take(evs[1]),
      .exc_code(ecode), .exc_pc(ev_val), .int_vector(3'h1), .int_pending(6'h00),
      .err_take(evs[2]), .err_pc(ev_val), .dbg_take(evs[3]), .dbg_pc(ev_val),
      .dbg_cause(6'h2A), .exc_return(evs[4]), .dbg_return(evs[5]), .cpu_mode(cpu_mode),
      .int_enable(int_enable), .timer_irq(timer_irq), .exc_vector_base(exc_vector_base),
      .hw_access_enable(hw_access_enable), .shadow_set(shadow_set),
      .vector_spacing(vector_spacing));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic rd(input logic [4:0] n, input logic [2:0] s);
      core.move(1'b1, 1'b0, n, s, 32'h0, rdat, hit);
   endtask : rd
   task automatic wr(input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
      core.move(1'b0, 1'b1, n, s, d, rdat, hit);
   endtask : wr
   // One-cycle event pulse with its pc or address
   task automatic ev(input logic [5:0] which, input logic [31:0] v);
      @(posedge clk_sys);
      evs <= which;
      ev_val <= v;
      @(posedge clk_sys);
      evs <= 6'h00;
      ev_val <= ~v;
      #1;
   endtask : ev
   task automatic t_reset();
      rd(NUM_STATUS, SEL_0); chk("status", rdat, STATUS_RST);
      rd(NUM_PROCESSOR_ID_REVISION, SEL_0); chk("processor_id_revision", rdat, PROCESSOR_ID_REVISION_VALUE);
      chk("processor_id_revision hit", {31'h0, hit}, 32'h1);
      rd(NUM_PROCESSOR_ID_REVISION, SEL_1); chk("exception_vector_base", rdat, EXCEPTION_VECTOR_BASE_RST);
      chk("vector", exc_vector_base, BOOT_VECTOR);
      chk("mode", {29'h0, cpu_mode}, 32'h1);
   endtask : t_reset
   // Every reserved number ignores writes and reads zero without a hit
   task automatic t_reserved();
      for (int n = 0; n < 32; n++) begin
         if (n < 7 || n == 10 || (n > 16 && n < 23) || (n > 24 && n < 30)) begin
            wr(n[4:0], SEL_0, 32'hFFFF_FFFF);
            rd(n[4:0], SEL_0); chk("reserved", {rdat[31:1], rdat[0] | hit}, 32'h0);
         end
      end
   endtask : t_reserved
   task automatic t_regs();
      wr(NUM_SCRATCH, SEL_0, 32'hA5C3_3C5A);
      rd(NUM_SCRATCH, SEL_0); chk("scratch", rdat, 32'hA5C3_3C5A);
      wr(NUM_HWENA, SEL_0, 32'hFFFF_FFFF);
      rd(NUM_HWENA, SEL_0); chk("hwena", rdat, HWENA_WMASK);
      chk("hwena out", {28'h0, hw_access_enable}, 32'hF);
      wr(NUM_STATUS, SEL_1, 32'hFFFF_FFFF);
      rd(NUM_STATUS, SEL_1); chk("interrupt_control_reg", rdat, INTERRUPT_CONTROL_REG_FIXED | INTERRUPT_CONTROL_REG_WMASK);
      chk("spacing", {27'h0, vector_spacing}, 32'h1F);
      wr(NUM_STATUS, SEL_2, 32'hFFFF_FFFF);
      rd(NUM_STATUS, SEL_2); chk("shadow_set_control", rdat, SHADOW_SET_CONTROL_WMASK);
      wr(NUM_STATUS, SEL_3, 32'h7654_3210);
      rd(NUM_STATUS, SEL_3); chk("shadow_set_map", rdat, 32'h7654_3210);
      wr(NUM_CONFIG, SEL_0, 32'h0);
      rd(NUM_CONFIG, SEL_0); chk("config0", rdat, CONFIG0_VAL);
      rd(NUM_CONFIG, SEL_3); chk("config3", rdat, CONFIG3_VAL);
   endtask : t_regs
   task automatic t_exc();
      ev(6'h01, 32'h1234_5678);
      wr(NUM_FAULTADR, SEL_0, 32'h0);
      rd(NUM_FAULTADR, SEL_0); chk("fault addr", rdat, 32'h1234_5678);
      ev(6'h02, 32'h9D00_0100);
      rd(NUM_CAUSE, SEL_0); chk("cause code", rdat & 32'h7C, 32'h10);
      rd(NUM_EXCPC, SEL_0); chk("return pc", rdat, 32'h9D00_0100);
      rd(NUM_STATUS, SEL_0); chk("exl erl", rdat & 32'h6, 32'h6);
      chk("int off", {31'h0, int_enable}, 32'h0);
      ev(6'h10, 32'h0);
      rd(NUM_STATUS, SEL_0); chk("erl cleared", rdat & 32'h6, 32'h2);
      ev(6'h04, 32'h9D00_0200);
      rd(NUM_ERRPC, SEL_0); chk("error pc", rdat, 32'h9D00_0200);
   endtask : t_exc
   task automatic t_dbg();
      ev(6'h08, 32'h9D00_0300);
      chk("debug mode", {29'h0, cpu_mode}, 32'h4);
      rd(NUM_DBGPC, SEL_0); chk("debug pc", rdat, 32'h9D00_0300);
      rd(NUM_DEBUG, SEL_0); chk("debug cause", rdat & 32'h3F, 32'h2A);
      ev(6'h20, 32'h0);
      chk("kernel again", {29'h0, cpu_mode}, 32'h1);
   endtask : t_dbg
   // Compare write clears the pending match; counting up sets it again
   task automatic t_timer();
      wr(NUM_COUNT, SEL_0, 32'h0);
      wr(NUM_COMPARE, SEL_0, 32'h40);
      rd(NUM_CAUSE, SEL_0); chk("timer clear", rdat[31:30], 2'h0);
      repeat (80) @(posedge clk_sys);
      rd(NUM_CAUSE, SEL_0); chk("timer set", rdat[31:30], 2'h1);
   endtask : t_timer
   // Enabled timer in user mode; an interrupt switches shadow sets and back
   task automatic t_irq();
      wr(NUM_STATUS, SEL_0, 32'h0000_8011);
      chk("irq", {30'h0, int_enable, timer_irq}, 32'h3);
      chk("user mode", {29'h0, cpu_mode}, 32'h2);
      chk("vector exception_vector_base", exc_vector_base, EXCEPTION_VECTOR_BASE_RST + GEN_VEC_OFS);
      ecode <= CODE_INT;
      ev(6'h02, 32'h9D00_0400);
      chk("shadow", {28'h0, shadow_set}, 32'h1);
      ev(6'h10, 32'h0);
      chk("shadow back", {28'h0, shadow_set}, 32'h0);
      chk("user again", {29'h0, cpu_mode}, 32'h2);
   endtask : t_irq
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_reserved();
      t_regs();
      t_exc();
      t_dbg();
      t_timer();
      t_irq();
      test_done();
   end
endmodule : tb_top
